/* rtl/result_limit_pkg.sv */
// Constants shared by the result and upper-limit register slice.
// Assumes one system clock; register indices are the serial-port addresses.
package result_limit_pkg;

    // Register and field widths
    localparam int unsigned DATA_W = 24;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned SEL_W  = 4;
    localparam int unsigned NUM_LIM = 4;

    // Register addresses on the serial port
    localparam logic [ADDR_W-1:0] ADDR_UPPER_LIMIT_SLOT4 = 7'h2c;
    localparam logic [ADDR_W-1:0] ADDR_UPPER_LIMIT_SLOT5 = 7'h2d;
    localparam logic [ADDR_W-1:0] ADDR_UPPER_LIMIT_SLOT6 = 7'h2e;
    localparam logic [ADDR_W-1:0] ADDR_UPPER_LIMIT_SLOT7 = 7'h2f;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_SLOT0      = 7'h30;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_SLOT1      = 7'h31;

    // Reset values (none printed, cleared here)
    localparam logic [DATA_W-1:0] DATA_RESET = 24'h000000;

    // Slot numbers as coded in the destination selectors
    localparam logic [SEL_W-1:0] SLOT0_CODE = 4'h0;
    localparam logic [SEL_W-1:0] SLOT1_CODE = 4'h1;

    // Serial frame layout: 8-bit command {read, addr[6:0]}, then 24 data bits
    localparam int unsigned CMD_BITS   = 8;
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned CMD_RD_BIT = 7;
    localparam logic [5:0]  CMD_LAST   = 6'h07;
    localparam logic [5:0]  FRAME_LAST = 6'h1f;

    // Serial engine phases
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CMD,
        PH_DATA,
        PH_DONE
    } spi_phase_t;

endpackage : result_limit_pkg

/* rtl/result_limit_regs.sv */
// Upper-limit registers for slots 4..7, result registers for slots 0 and 1,
// the over-range comparators and the serial register port that reaches them.
// Assumes serial pins from outside the clock domain, mode 0, MSB first, and
// coding settings and conversion strobes from logic on the same clock.
`timescale 1ns/1ps

module result_limit_regs
(
    // Clock and reset
    input  wire logic                                          clk_in,
    input  wire logic                                          sys_rst_in,
    // Serial register port
    input  wire logic                                          sclk_in,
    input  wire logic                                          cs_n_in,
    input  wire logic                                          mosi_in,
    output logic                                               miso_out,
    output logic                                               miso_oe_out,
    // Conversion results and destination selection
    input  wire logic                                          conv_done_in,
    input  wire logic [result_limit_pkg::DATA_W-1:0]           conv_data_in,
    input  wire logic [result_limit_pkg::SEL_W-1:0]            primary_slot_select_in,
    input  wire logic [result_limit_pkg::SEL_W-1:0]            gpio_slot_select_in,
    // Coding settings
    input  wire logic                                          polarity_select_in,
    input  wire logic                                          format_select_in,
    // Stored results of slots 4..7, held by the rest of the result store
    input  wire logic [result_limit_pkg::NUM_LIM-1:0][result_limit_pkg::DATA_W-1:0] slot_hi_result_in,
    // Over-range flags for slots 4..7 and slot 0/1 contents
    output logic [result_limit_pkg::NUM_LIM-1:0]               over_range_flag_out,
    output logic [result_limit_pkg::DATA_W-1:0]                result_slot0_out,
    output logic [result_limit_pkg::DATA_W-1:0]                result_slot1_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0]                          sclk_s_q;
    logic [1:0]                          cs_n_s_q;
    logic [1:0]                          mosi_s_q;
    logic                                sclk_rise;
    logic                                sclk_fall;
    logic                                cs_act;

    // Two stages on every pin and a third on sclk, so edges are seen on settled samples only
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sclk_s_q <= 3'h0;
            cs_n_s_q <= 2'h3;
            mosi_s_q <= 2'h0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_in};
            cs_n_s_q <= {cs_n_s_q[0], cs_n_in};
            mosi_s_q <= {mosi_s_q[0], mosi_in};
        end
    end

    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    assign cs_act    = ~cs_n_s_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame engine
    result_limit_pkg::spi_phase_t        phase_q;
    logic [5:0]                          bit_cnt_q;
    logic [result_limit_pkg::DATA_W-1:0] rx_shift_q;
    logic [result_limit_pkg::DATA_W-1:0] tx_shift_q;
    logic [result_limit_pkg::ADDR_W-1:0] addr_q;
    logic                                rd_q;
    logic                                wr_commit;
    logic [result_limit_pkg::DATA_W-1:0] rd_data;
    logic [result_limit_pkg::NUM_LIM-1:0][result_limit_pkg::DATA_W-1:0] upper_limit_q;
    logic [result_limit_pkg::DATA_W-1:0] result_slot0_q;
    logic [result_limit_pkg::DATA_W-1:0] result_slot1_q;

    // Write commits one clock after the last rise, once that bit is in the shifter
    assign wr_commit = (phase_q == result_limit_pkg::PH_DONE) && cs_act && !rd_q
                       && (bit_cnt_q == 6'(result_limit_pkg::FRAME_BITS));

    // Read data mux; unmapped addresses read as zero
    always_comb
    begin
        case (addr_q)
            result_limit_pkg::ADDR_UPPER_LIMIT_SLOT4: rd_data = upper_limit_q[0];
            result_limit_pkg::ADDR_UPPER_LIMIT_SLOT5: rd_data = upper_limit_q[1];
            result_limit_pkg::ADDR_UPPER_LIMIT_SLOT6: rd_data = upper_limit_q[2];
            result_limit_pkg::ADDR_UPPER_LIMIT_SLOT7: rd_data = upper_limit_q[3];
            result_limit_pkg::ADDR_RESULT_SLOT0:      rd_data = result_slot0_q;
            result_limit_pkg::ADDR_RESULT_SLOT1:      rd_data = result_slot1_q;
            default:                                  rd_data = result_limit_pkg::DATA_RESET;
        endcase
    end

    // Frame sequencing; raising chip select aborts any frame at once
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            phase_q    <= result_limit_pkg::PH_IDLE;
            bit_cnt_q  <= 6'h00;
            rx_shift_q <= result_limit_pkg::DATA_RESET;
            addr_q     <= 7'h00;
            rd_q       <= 1'b0;
        end
        else if (!cs_act)
        begin
            phase_q   <= result_limit_pkg::PH_IDLE;
            bit_cnt_q <= 6'h00;
        end
        else
        begin
            case (phase_q)
                result_limit_pkg::PH_IDLE:
                begin
                    phase_q   <= result_limit_pkg::PH_CMD;
                    bit_cnt_q <= 6'h00;
                end
                result_limit_pkg::PH_CMD:
                begin
                    if (sclk_rise)
                    begin
                        rx_shift_q <= {rx_shift_q[result_limit_pkg::DATA_W-2:0], mosi_s_q[1]};
                        bit_cnt_q  <= bit_cnt_q + 6'h01;
                        if (bit_cnt_q == result_limit_pkg::CMD_LAST)
                        begin
                            rd_q    <= rx_shift_q[result_limit_pkg::CMD_RD_BIT-1];
                            addr_q  <= {rx_shift_q[result_limit_pkg::ADDR_W-2:0], mosi_s_q[1]};
                            phase_q <= result_limit_pkg::PH_DATA;
                        end
                    end
                end
                result_limit_pkg::PH_DATA:
                begin
                    if (sclk_rise)
                    begin
                        rx_shift_q <= {rx_shift_q[result_limit_pkg::DATA_W-2:0], mosi_s_q[1]};
                        bit_cnt_q  <= bit_cnt_q + 6'h01;
                        if (bit_cnt_q == result_limit_pkg::FRAME_LAST)
                        begin
                            phase_q <= result_limit_pkg::PH_DONE;
                        end
                    end
                end
                result_limit_pkg::PH_DONE:
                begin
                    phase_q <= result_limit_pkg::PH_DONE; // Extra clocks ignored until deselect
                    bit_cnt_q <= 6'h00; // Count cleared so a write commits only once
                end
                default:
                begin
                    phase_q <= result_limit_pkg::PH_IDLE;
                end
            endcase
        end
    end

    // Read data is captured on the first data-phase clock, when the address is final, then shifted on falls
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            tx_shift_q  <= result_limit_pkg::DATA_RESET;
            miso_out    <= 1'b0;
            miso_oe_out <= 1'b0;
        end
        else
        begin
            miso_oe_out <= cs_act && rd_q && (phase_q == result_limit_pkg::PH_DATA);
            if ((phase_q == result_limit_pkg::PH_DATA) && !miso_oe_out)
            begin
                tx_shift_q <= rd_data;
            end
            else if ((phase_q == result_limit_pkg::PH_DATA) && sclk_fall)
            begin
                miso_out   <= tx_shift_q[result_limit_pkg::DATA_W-1];
                tx_shift_q <= {tx_shift_q[result_limit_pkg::DATA_W-2:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Upper limit registers
    // Host writes only; software must refresh them after a coding change
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            upper_limit_q <= '0;
        end
        else if (wr_commit)
        begin
            case (addr_q)
                result_limit_pkg::ADDR_UPPER_LIMIT_SLOT4: upper_limit_q[0] <= rx_shift_q;
                result_limit_pkg::ADDR_UPPER_LIMIT_SLOT5: upper_limit_q[1] <= rx_shift_q;
                result_limit_pkg::ADDR_UPPER_LIMIT_SLOT6: upper_limit_q[2] <= rx_shift_q;
                result_limit_pkg::ADDR_UPPER_LIMIT_SLOT7: upper_limit_q[3] <= rx_shift_q;
                default:                                  upper_limit_q    <= upper_limit_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result slots 0 and 1
    logic hit_slot0;
    logic hit_slot1;

    // A slot is chosen when either selector names it
    assign hit_slot0 = (primary_slot_select_in == result_limit_pkg::SLOT0_CODE)
                       || (gpio_slot_select_in == result_limit_pkg::SLOT0_CODE);
    assign hit_slot1 = (primary_slot_select_in == result_limit_pkg::SLOT1_CODE)
                       || (gpio_slot_select_in == result_limit_pkg::SLOT1_CODE);

    // A finishing conversion wins over a host write in the same cycle
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            result_slot0_q <= result_limit_pkg::DATA_RESET;
            result_slot1_q <= result_limit_pkg::DATA_RESET;
        end
        else
        begin
            if (conv_done_in && hit_slot0)
            begin
                result_slot0_q <= conv_data_in;
            end
            else if (wr_commit && (addr_q == result_limit_pkg::ADDR_RESULT_SLOT0))
            begin
                result_slot0_q <= rx_shift_q;
            end
            if (conv_done_in && hit_slot1)
            begin
                result_slot1_q <= conv_data_in;
            end
            else if (wr_commit && (addr_q == result_limit_pkg::ADDR_RESULT_SLOT1))
            begin
                result_slot1_q <= rx_shift_q;
            end
        end
    end

    // Copies for the rest of the result store
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            result_slot0_out <= result_limit_pkg::DATA_RESET;
            result_slot1_out <= result_limit_pkg::DATA_RESET;
        end
        else
        begin
            result_slot0_out <= result_slot0_q;
            result_slot1_out <= result_slot1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Over-range comparison for slots 4..7
    logic signed_cmp;

    // Only bipolar two's complement data is ordered as signed numbers
    assign signed_cmp = polarity_select_in && format_select_in;

    // Compared every cycle, so a new result or limit is seen one clock later
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            over_range_flag_out <= '0;
        end
        else
        begin
            for (int i = 0; i < result_limit_pkg::NUM_LIM; i++)
            begin
                if (signed_cmp)
                begin
                    over_range_flag_out[i] <= $signed(slot_hi_result_in[i]) > $signed(upper_limit_q[i]);
                end
                else
                begin
                    over_range_flag_out[i] <= slot_hi_result_in[i] > upper_limit_q[i];
                end
            end
        end
    end

endmodule : result_limit_regs

/* verification/result_limit_chk.sv */
// Port-level checker for the result and upper-limit slice.
// Assumes the host keeps chip select high between frames.
`timescale 1ns/1ps
module result_limit_chk
(
    // Clock, reset and serial port
    input wire logic             clk_in,
    input wire logic             sys_rst_in,
    input wire logic             cs_n_in,
    input wire logic             miso_oe_out,
    // Conversions, settings, results and flags
    input wire logic             conv_done_in,
    input wire logic [23:0]      conv_data_in,
    input wire logic [3:0]       primary_slot_select_in,
    input wire logic [3:0]       gpio_slot_select_in,
    input wire logic             polarity_select_in,
    input wire logic             format_select_in,
    input wire logic [3:0][23:0] slot_hi_result_in,
    input wire logic [3:0]       over_range_flag_out,
    input wire logic [23:0]      result_slot0_out,
    input wire logic [23:0]      result_slot1_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [3:0] idle_q;

    ////////////////////////////////////////
    // Cycles with the port closed; a late serial write cannot land once it reaches 8
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            idle_q <= 4'h0;
        else if (!cs_n_in)
            idle_q <= 4'h0;
        else if (idle_q != 4'hf)
            idle_q <= idle_q + 4'h1;
    end

    // Steps of a conversion hand-off
    sequence s_quiet; idle_q >= 4'h8; endsequence
    sequence s_to0; conv_done_in && (primary_slot_select_in == 4'h0 || gpio_slot_select_in == 4'h0); endsequence
    sequence s_to1; conv_done_in && (primary_slot_select_in == 4'h1 || gpio_slot_select_in == 4'h1); endsequence
    sequence s_miss; conv_done_in && primary_slot_select_in > 4'h1 && gpio_slot_select_in > 4'h1; endsequence
    property p_store0; s_to0 |=> ##1 result_slot0_out == $past(conv_data_in, 2); endproperty
    property p_store1; s_to1 |=> ##1 result_slot1_out == $past(conv_data_in, 2); endproperty
    property p_skip; s_quiet ##0 s_miss |=> ##1 $stable(result_slot0_out) && $stable(result_slot1_out); endproperty
    property p_zero; !(polarity_select_in && format_select_in) && slot_hi_result_in[0] == 24'h0
        |=> !over_range_flag_out[0]; endproperty
    property p_min; polarity_select_in && format_select_in && slot_hi_result_in[3] == 24'h800000
        |=> !over_range_flag_out[3]; endproperty
    property p_steady; s_quiet ##0 $stable(slot_hi_result_in) && $stable({polarity_select_in, format_select_in})
        |=> $stable(over_range_flag_out); endproperty
    property p_oe; s_quiet |-> !miso_oe_out; endproperty
    a_store0: assert property (p_store0) else $error("slot0 missed its result");
    a_store1: assert property (p_store1) else $error("slot1 missed its result");
    a_skip: assert property (p_skip) else $error("unselected slot changed");
    a_zero: assert property (p_zero) else $error("zero flagged over range");
    a_min: assert property (p_min) else $error("signed minimum flagged");
    a_steady: assert property (p_steady) else $error("flag moved with steady inputs");
    a_oe: assert property (p_oe) else $error("output enabled while idle");
endmodule : result_limit_chk

bind result_limit_regs result_limit_chk u_result_limit_chk
(
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in), .miso_oe_out(miso_oe_out),
    .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .primary_slot_select_in(primary_slot_select_in),
    .gpio_slot_select_in(gpio_slot_select_in), .polarity_select_in(polarity_select_in),
    .format_select_in(format_select_in), .slot_hi_result_in(slot_hi_result_in),
    .over_range_flag_out(over_range_flag_out), .result_slot0_out(result_slot0_out),
    .result_slot1_out(result_slot1_out)
);

/* verification/spi_host_model.sv */
// Serial host model driving register frames, mode 0, MSB first.
// Assumes a 125 MHz clk_in; sclk half period is six clocks.
`timescale 1ns/1ps
module spi_host_model
(
    // Clock
    input  wire logic clk_in,
    // Serial pins
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    // Clock stands low and the frame closed between tasks
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // One frame; fewer than 32 bits closes it early as an abort
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [23:0] wdata,
                        input int nbits, output logic [23:0] rdata);
        logic [31:0] frame;
        frame = {rd, addr, wdata};
        rdata = 24'h0;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            mosi_out <= frame[31-i];
            repeat (6) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i >= 8)
                rdata[31-i] = miso_in;
            repeat (6) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (6) @(posedge clk_in);
        cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out; // Released line shows no stale bit
        repeat (8) @(posedge clk_in);
    endtask : xfer
endmodule : spi_host_model

/* verification/test_result_limit_regs.sv */
// Self-checking bench for the result and upper-limit slice.
// Assumes the serial host model and the bound checker.
`timescale 1ns/1ps
module test_result_limit_regs;
    logic             clk_in = 1'b0;
    logic             sys_rst_in = 1'b1;
    logic             sclk_w, cs_n_w, mosi_w, miso_w, oe_w, conv_w, pol_w, fmt_w, ov;
    logic [23:0]      data_w, r0_w, r1_w, got, val, lim, res, exp0, exp1;
    logic [3:0]       psel_w, gsel_w, flag_w;
    logic [3:0][23:0] hi_w;
    int               fails = 0;
    int               checks_done = 0;

    always #4 clk_in = ~clk_in;

    spi_host_model u_spi_host_model
    (.clk_in(clk_in), .sclk_out(sclk_w), .cs_n_out(cs_n_w), .mosi_out(mosi_w), .miso_in(miso_w));

    result_limit_regs u_result_limit_regs
    (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk_w), .cs_n_in(cs_n_w), .mosi_in(mosi_w),
        .miso_out(miso_w), .miso_oe_out(oe_w), .conv_done_in(conv_w), .conv_data_in(data_w),
        .primary_slot_select_in(psel_w), .gpio_slot_select_in(gsel_w), .polarity_select_in(pol_w),
        .format_select_in(fmt_w), .slot_hi_result_in(hi_w), .over_range_flag_out(flag_w),
        .result_slot0_out(r0_w), .result_slot1_out(r1_w)
    );

    ////////////////////////////////////////
    // Strict greater-than, signed only for bipolar two's complement
    function automatic logic exp_over(input logic [23:0] r, input logic [23:0] l, input logic p, input logic f);
        if (p && f)
            return $signed(r) > $signed(l);
        return r > l;
    endfunction : exp_over

    task automatic check(input logic [23:0] g, input logic [23:0] e, input string what);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask : check

    task automatic results;
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Hang guard, well beyond the length of all frames
    initial
    begin
        repeat (60000) @(posedge clk_in);
        check(24'h1, 24'h0, "watchdog expired");
        results();
    end

    ////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h8c8d55ab));
        {conv_w, pol_w, fmt_w} = 3'h0;
        {data_w, exp0, exp1} = '0;
        {psel_w, gsel_w} = 8'hff;
        hi_w = '0;
        repeat (5) @(posedge clk_in);
        #1 check(r0_w | r1_w | {18'h0, flag_w, oe_w, miso_w}, 24'h0, "reset outputs");
        @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        // Every register written and read back, slot 1 register seen at its output
        for (int i = 0; i < 6; i++)
        begin
            val = 24'($urandom);
            u_spi_host_model.xfer(1'b0, 7'h2c + 7'(i), val, 32, got);
            u_spi_host_model.xfer(1'b1, 7'h2c + 7'(i), 24'h0, 32, got);
            check(got, val, "register readback");
            if (i == 0)
                lim = val;
            if (i == 4)
                exp0 = val;
        end
        check(r1_w, val, "slot1 output after write");
        exp1 = val;
        // Aborted frame must leave the limit alone; unmapped place reads zero
        u_spi_host_model.xfer(1'b0, 7'h2c, ~lim, 20, got);
        u_spi_host_model.xfer(1'b1, 7'h2c, 24'h0, 32, got);
        check(got, lim, "limit after abort");
        u_spi_host_model.xfer(1'b1, 7'h2b, 24'h0, 32, got);
        check(got, 24'h0, "unmapped read");
        // Conversions with both selectors drawn over slots 0..4
        for (int i = 0; i < 24; i++)
        begin
            val = 24'($urandom);
            @(posedge clk_in);
            conv_w <= 1'b1;
            data_w <= val;
            psel_w <= 4'($urandom_range(0, 4));
            gsel_w <= 4'($urandom_range(0, 4));
            @(posedge clk_in);
            conv_w <= 1'b0;
            if (psel_w == 4'h0 || gsel_w == 4'h0)
                exp0 = val;
            if (psel_w == 4'h1 || gsel_w == 4'h1)
                exp1 = val;
            @(posedge clk_in);
            #1 check(r0_w, exp0, "slot0 store");
            check(r1_w, exp1, "slot1 store");
        end
        u_spi_host_model.xfer(1'b1, 7'h30, 24'h0, 32, got);
        check(got, exp0, "slot0 serial read");
        // Each coding mode, limits rewritten after the change, equal/above/minimum/random results
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 4; s++)
            begin
                {pol_w, fmt_w} <= 2'(m);
                lim = 24'($urandom);
                u_spi_host_model.xfer(1'b0, 7'h2c + 7'(s), lim, 32, got);
                for (int k = 0; k < 4; k++)
                begin
                    res = (k == 0) ? lim : (k == 1) ? lim + 24'h1 : (k == 2) ? 24'h800000 : 24'($urandom);
                    @(posedge clk_in);
                    hi_w[s] <= res;
                    repeat (2) @(posedge clk_in);
                    ov = exp_over(res, lim, pol_w, fmt_w);
                    #1 check({23'h0, flag_w[s]}, {23'h0, ov}, "over-range flag");
                end
            end
        results();
    end
endmodule : test_result_limit_regs
